// ==== design/ahb_pkg.sv ====
package ahb_pkg;
  // Bus style select.
  typedef enum logic {AHB_STYLE_STROBE_PAIR, AHB_STYLE_DIR_STROBE} ahb_style_e;
  localparam int AHB_DATA_W = 8;
  localparam int AHB_ADDR_W = 8;
  // Clock period and access time in ns; the access time is rounded up to clock cycles.
  localparam int AHB_CLK_NS = 20;
  localparam int AHB_ACCESS_NS = 40;
  localparam int AHB_ACCESS_CYC = (AHB_ACCESS_NS + AHB_CLK_NS - 1) / AHB_CLK_NS;
  localparam logic [7:0] AHB_RDATA_RST = 8'h00;
  localparam logic AHB_DONE_IDLE = 1'b1;
endpackage : ahb_pkg

// ==== design/ahb_sync_if.sv ====
`timescale 1ns/10ps
// Synchronised strobe, direction, data and address levels passed from the pin stage to the core.
interface ahb_sync_if;
  logic wr_n;
  logic ds_n;
  logic rd_dir;
  logic [7:0] data;
  logic [7:0] addr;
  modport src (output wr_n, ds_n, rd_dir, data, addr);
  modport dst (input wr_n, ds_n, rd_dir, data, addr);
endinterface : ahb_sync_if

// ==== design/ahb_pin_sync.sv ====
`timescale 1ns/10ps
// Two-flop synchroniser for every host pin that the core reads.
module ahb_pin_sync
  import ahb_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_sync_n,
  // Raw pins.
  input wire logic write_strobe_n,
  input wire logic read_data_strobe_n,
  input wire logic rd_dir,
  input wire logic [AHB_DATA_W-1:0] data_in,
  input wire logic [AHB_ADDR_W-1:0] addr,
  // Synchronised levels.
  ahb_sync_if.src sync
);
  logic [1:0] wr_q;
  logic [1:0] ds_q;
  logic [1:0] dir_q;
  logic [AHB_DATA_W-1:0] data_q [2];
  logic [AHB_ADDR_W-1:0] addr_q [2];

  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      wr_q <= 2'h3;
      ds_q <= 2'h3;
      dir_q <= 2'h0;
      data_q[0] <= 8'h00;
      data_q[1] <= 8'h00;
      addr_q[0] <= 8'h00;
      addr_q[1] <= 8'h00;
    end
    else
    begin
      wr_q <= {wr_q[0], write_strobe_n};
      ds_q <= {ds_q[0], read_data_strobe_n};
      dir_q <= {dir_q[0], rd_dir};
      data_q[0] <= data_in;
      data_q[1] <= data_q[0];
      addr_q[0] <= addr;
      addr_q[1] <= addr_q[0];
    end
  end

  assign sync.wr_n = wr_q[1];
  assign sync.ds_n = ds_q[1];
  assign sync.rd_dir = dir_q[1];
  assign sync.data = data_q[1];
  assign sync.addr = addr_q[1];
endmodule : ahb_pin_sync

// ==== design/ahb_host_port.sv ====
`timescale 1ns/10ps
// What this block does
// - Strobe-pair style: write strobe input is active low, driven by host.
// - Strobe-pair style: once the synchronised write strobe is low, data pins are inputs (output enable off).
// - Data pins are captured into the addressed location when the access-time count ends.
// - Data-strobe style: direction high at strobe fall means a read.
// - Data-strobe style: direction low at strobe fall means a write.
// - Completion output acts as ready or transfer acknowledge per style.
// - Strobe-pair: ready stays high during a cycle until it can complete.
module ahb_host_port
  import ahb_pkg::*;
#(
  parameter int ACCESS_CYC = AHB_ACCESS_CYC,
  parameter int DEPTH = 256
)
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Bus style select, static during operation.
  input wire ahb_pkg::ahb_style_e bus_style,
  // Host strobes and address.
  input wire logic write_strobe_n,
  input wire logic read_data_strobe_n,
  input wire logic rd_dir,
  input wire logic [ahb_pkg::AHB_ADDR_W-1:0] addr,
  // Data pins, split into three signals.
  input wire logic [ahb_pkg::AHB_DATA_W-1:0] data_in,
  output logic [ahb_pkg::AHB_DATA_W-1:0] data_out,
  output logic data_oe,
  // Completion output.
  output logic cycle_done_out
);
  typedef enum logic [1:0] {AHB_IDLE, AHB_WAIT, AHB_DONE} ahb_state_e;

  logic [1:0] rst_q;
  logic rst_sync_n;
  ahb_sync_if sync ();
  ahb_state_e state_q, state_d;
  logic [7:0] cnt_q, cnt_d;
  logic is_read_q, is_read_d;
  logic ds_prev_q, wr_prev_q;
  logic [AHB_DATA_W-1:0] mem [DEPTH];
  logic [AHB_DATA_W-1:0] data_out_d;
  logic data_oe_d;
  logic done_d;

  // Falling edge of an active-low strobe, seen on two successive synchronised samples.
  // Every strobe goes through this one test, so all strobes start a cycle with the same
  // latency.
  function automatic logic ahb_fell(input logic prev_n, input logic now_n);
    return prev_n && !now_n;
  endfunction : ahb_fell

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rst_q <= 2'h0;
    else
      rst_q <= {rst_q[0], 1'b1};
  end
  assign rst_sync_n = rst_q[1];

  ahb_pin_sync u_sync (
    .mclk(mclk),
    .rst_sync_n(rst_sync_n),
    .write_strobe_n(write_strobe_n),
    .read_data_strobe_n(read_data_strobe_n),
    .rd_dir(rd_dir),
    .data_in(data_in),
    .addr(addr),
    .sync(sync.src)
  );

  wire pair_style = (bus_style == AHB_STYLE_STROBE_PAIR);
  // The write strobe is only meaningful in the strobe-pair style.
  wire wr_act = pair_style && !sync.wr_n;
  wire rd_act = pair_style ? !sync.ds_n : 1'b0;
  wire ds_act = !pair_style && !sync.ds_n;
  // One strobe pin serves as the read strobe or as the data strobe, depending on the style.
  wire ds_fall = !pair_style && ahb_fell(ds_prev_q, sync.ds_n);
  wire wr_fall = pair_style && ahb_fell(wr_prev_q, sync.wr_n);
  wire rd_fall = pair_style && ahb_fell(ds_prev_q, sync.ds_n);
  wire start = ds_fall || wr_fall || rd_fall;
  // Direction is sampled only at the strobe fall.
  wire start_read = ds_fall ? sync.rd_dir : rd_fall;
  wire strobe_held = wr_act || rd_act || ds_act;
  wire cnt_end = (cnt_q == 8'(ACCESS_CYC - 1));

  // The cycle sequencer. A strobe fall moves it from idle to the wait state, where it counts
  // the access time. After that it sits in the done state until the host lets go of its
  // strobe. If the strobe is released early, the cycle is dropped and nothing is written.
  // A host that drives both strobes at once gets whichever the decode meets first, so it
  // must not do that.
  // The address and data pins cross domains as plain two-flop copies. This is safe only
  // because the host keeps them steady from before its strobe falls until the completion
  // output has gone low. The strobe goes through the same two flops, so by the time the
  // core sees the strobe the copies have settled.
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    is_read_d = is_read_q;
    case (state_q)
      AHB_IDLE:
      begin
        if (start)
        begin
          state_d = AHB_WAIT;
          cnt_d = 8'h00;
          is_read_d = start_read;
        end
      end
      AHB_WAIT:
      begin
        if (!strobe_held)
          state_d = AHB_IDLE;
        else if (cnt_end)
          state_d = AHB_DONE;
        else
          cnt_d = cnt_q + 8'h01;
      end
      // Completion holds until the host drops its strobe.
      AHB_DONE:
      begin
        if (!strobe_held)
          state_d = AHB_IDLE;
      end
      default:
        state_d = AHB_IDLE;
    endcase
  end

  // Write lands once the data has been stable through the access time.
  wire do_write = (state_q == AHB_WAIT) && cnt_end && strobe_held && !is_read_q;
  wire do_read = (state_q != AHB_IDLE) && is_read_q && strobe_held;

  // Same polarity for both styles; the meaning differs by style.
  assign done_d = (state_q == AHB_DONE) ? 1'b0 : AHB_DONE_IDLE;
  // Stop driving once the synchronised write strobe is low in the strobe-pair style; data_oe falls on the third mclk edge after the pin falls.
  assign data_oe_d = do_read && !wr_act;
  assign data_out_d = do_read ? mem[sync.addr] : AHB_RDATA_RST;

  always_ff @(posedge mclk)
  begin
    if (do_write)
      mem[sync.addr] <= sync.data;
  end

  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      state_q <= AHB_IDLE;
      cnt_q <= 8'h00;
      is_read_q <= 1'b0;
      ds_prev_q <= 1'b1;
      wr_prev_q <= 1'b1;
      data_out <= AHB_RDATA_RST;
      data_oe <= 1'b0;
      cycle_done_out <= AHB_DONE_IDLE;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      is_read_q <= is_read_d;
      ds_prev_q <= sync.ds_n;
      wr_prev_q <= sync.wr_n;
      data_out <= data_out_d;
      data_oe <= data_oe_d;
      cycle_done_out <= done_d;
    end
  end
endmodule : ahb_host_port

// ==== dv/ahb_host_port_assertions.sv ====
`timescale 1ns/10ps
module ahb_chk
  import ahb_pkg::*;
(
  // Watched ports.
  input wire logic mclk,
  input wire logic rst_n,
  input wire ahb_pkg::ahb_style_e bus_style,
  input wire logic write_strobe_n,
  input wire logic read_data_strobe_n,
  input wire logic rd_dir,
  input wire logic data_oe,
  input wire logic cycle_done_out
);
  wire st_n = write_strobe_n & read_data_strobe_n;
  wire ds_n = read_data_strobe_n;
  wire done_n = cycle_done_out;
  wire dir = bus_style == AHB_STYLE_DIR_STROBE;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  chk_wr_no_oe: assert property (!write_strobe_n |-> !data_oe)
    else $error("oe in write");
  chk_done_late: assert property ($fell(st_n) |-> done_n [*3])
    else $error("done early");
  chk_done_soon: assert property ($fell(st_n) |-> ##[3:9] !done_n)
    else $error("done late");
  chk_done_holds: assert property (!st_n && !done_n |=> !done_n)
    else $error("done lost");
  chk_idle_high: assert property (st_n [*5] |-> done_n)
    else $error("done idle");
  chk_rd_drive: assert property (!dir && !ds_n && !done_n |-> data_oe)
    else $error("no drive");
  chk_dir_rd: assert property (dir && $fell(ds_n) && rd_dir |-> ##[2:8] data_oe)
    else $error("no dir read");
  chk_dir_wr: assert property (dir && !ds_n && !rd_dir |-> !data_oe)
    else $error("oe in dir write");
  cv_pair_wr: cover property (!dir && !write_strobe_n && !done_n);
  cv_pair_rd: cover property (!dir && !ds_n && data_oe);
  cv_dir_rd: cover property (dir && !ds_n && data_oe);
endmodule : ahb_chk
bind ahb_host_port ahb_chk u_chk (.*);

// ==== dv/ahb_host_model.sv ====
`timescale 1ns/10ps
module ahb_host_model
  import ahb_pkg::*;
(
  // Clock.
  input wire logic mclk,
  // Host pins.
  output logic write_strobe_n = 1'b1,
  output logic read_data_strobe_n = 1'b1,
  output logic rd_dir = 1'b0,
  output logic [ahb_pkg::AHB_ADDR_W-1:0] addr = 8'h00,
  output logic [ahb_pkg::AHB_DATA_W-1:0] data_in,
  // Device answer.
  input wire logic [ahb_pkg::AHB_DATA_W-1:0] data_out,
  input wire logic data_oe,
  input wire logic cycle_done_out
);
  logic [7:0] hd_q = 8'h5a;
  // A released line shows the inverse of its last value, so a stale byte cannot pass.
  assign data_in = data_oe ? data_out : hd_q;
  task automatic xfer(input ahb_style_e s, input logic rd, input logic [7:0] a, d,
    output logic [7:0] q);
    int n = 0;
    @(posedge mclk) #1 addr = a;
    rd_dir = rd;
    hd_q = rd ? hd_q : d;
    write_strobe_n = !(s == AHB_STYLE_STROBE_PAIR && !rd);
    read_data_strobe_n = s == AHB_STYLE_STROBE_PAIR && !rd;
    do @(posedge mclk); while (cycle_done_out !== 1'b0 && ++n < 20);
    q = data_out;
    #1 write_strobe_n = 1'b1;
    read_data_strobe_n = 1'b1;
    hd_q = ~hd_q;
    do @(posedge mclk); while (cycle_done_out !== 1'b1 && ++n < 40);
    repeat (2) @(posedge mclk);
    #1;
  endtask : xfer
endmodule : ahb_host_model

// ==== dv/tb.sv ====
`timescale 1ns/10ps
module tb;
  import ahb_pkg::*;
  logic mclk = 1'b0;
  logic rst_n, write_strobe_n, read_data_strobe_n, rd_dir, data_oe, cycle_done_out;
  logic [7:0] addr, data_in, data_out, q;
  ahb_style_e bus_style;
  int error_cnt = 0;
  int n_compared = 0;
  logic [15:0] lfsr_q = 16'h2073;
  logic [7:0] mem [256];
  logic [7:0] aq [8];
  ahb_host_port DUT (.*);
  ahb_host_model u_host (.*);
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr_next
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    error_cnt += (got !== exp);
    if (got !== exp)
      $display("MISMATCH %0t read %h exp %h", $time, got, exp);
  endtask : cmp_byte
  task automatic cmp_bit(input logic got, input logic exp);
    n_compared++;
    error_cnt += (got !== exp);
    if (got !== exp)
      $display("MISMATCH %0t flag %b exp %b", $time, got, exp);
  endtask : cmp_bit
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test
  initial forever #10 mclk = ~mclk;
  // About 32 transfers of under 30 cycles each.
  initial
  begin
    repeat (3000) @(posedge mclk);
    error_cnt++;
    $display("MISMATCH %0t run did not finish", $time);
    stop_test();
  end
  initial
  begin
    rst_n = 1'b0;
    bus_style = AHB_STYLE_STROBE_PAIR;
    repeat (5) @(posedge mclk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge mclk);
    for (int s = 0; s < 2; s++)
    begin
      bus_style = ahb_style_e'(s);
      for (int i = 0; i < 8; i++)
      begin
        lfsr_q = lfsr_next(lfsr_q);
        aq[i] = i < 2 ? {8{i[0]}} : lfsr_q[7:0];
        mem[aq[i]] = i < 2 ? ~aq[i] : lfsr_q[15:8];
        u_host.xfer(bus_style, 1'b0, aq[i], mem[aq[i]], q);
        cmp_bit(cycle_done_out, AHB_DONE_IDLE);
        cmp_bit(data_oe, 1'b0);
      end
      // Reading back in the other style proves both styles reach one store.
      bus_style = ahb_style_e'(1 - s);
      for (int i = 7; i >= 0; i--)
      begin
        u_host.xfer(bus_style, 1'b1, aq[i], 8'h00, q);
        cmp_byte(q, mem[aq[i]]);
        cmp_bit(data_oe, 1'b0);
      end
      $display("test style %0d done", s);
    end
    stop_test();
  end
endmodule : tb
